// ### rtl/restart_pkg.sv
// Package: constants and types of the fault auto-restart sequencer
package restart_pkg;
  // Retry budget range and default
  localparam logic [3:0]  BUDGET_MAX       = 4'ha;
  localparam logic [3:0]  BUDGET_RESET     = 4'h0;
  // Restart delay in tenths of a second, range and default
  localparam logic [9:0]  DELAY_MAX        = 10'h258;
  localparam logic [9:0]  DELAY_RESET      = 10'h00a;
  // Quiet window after an automatic restart, in tenths of a second
  localparam int          QUIET_TENTHS     = 300;
  localparam logic [9:0]  QUIET_COUNT      = 10'(QUIET_TENTHS);
  // Clock rate and the tenth-second tick derived from it
  localparam int          CLK_HZ           = 125_000_000;
  localparam int          TENTH_MS         = 100;
  localparam int          TENTH_CYCLES     = CLK_HZ / 1000 * TENTH_MS;
  // Excluded trip causes, bit positions in the cause vector
  localparam int          CAUSE_W          = 4;
  localparam int          CAUSE_UNDERVOLT  = 0;
  localparam int          CAUSE_ESTOP      = 1;
  localparam int          CAUSE_OVERHEAT   = 2;
  localparam int          CAUSE_SELFDIAG   = 3;
  // Flying start settings field width
  localparam int          FLY_W            = 4;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN     = 3'b000,
    ST_TRIPPED = 3'b001,
    ST_WAIT    = 3'b010,
    ST_LOCKED  = 3'b011
  } seq_state_type;
endpackage

// ### rtl/tick_divider.sv
// Divider that gives a one-cycle enable every PERIOD clocks
`timescale 1ns/1ps
module tick_divider #(
  parameter int PERIOD = 12_500_000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Enable pulse
  output logic      tick
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] count;
  wire           wrap = (count == LAST);

  // Free-running count; tick marks the wrap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
      tick  <= wrap;
    end
  end
endmodule // tick_divider

// ### rtl/fault_auto_restart_sequencer.sv
// Fault auto-restart sequencer of a motor drive
// Functional notes
// - Retry budget setting 0..10, default 0 meaning no automatic restarts.
// - Restart delay 0.0..60.0 s in tenths, default 1.0 s.
// - After a trip, a run command then starts restart after the delay.
// - Each automatic restart decrements remaining retries; none when zero.
// - Manual reset from terminal or keypad reloads remaining retries.
// - No trip within 30 s after restart reloads remaining retries.
// - Undervoltage, emergency stop, overheat, self-diagnosis trips while running never restart; ignored while tripped or waiting.
// - Restart begins acceleration using the flying start settings.
`timescale 1ns/1ps
module fault_auto_restart_sequencer
  import restart_pkg::*;
#(
  parameter int TICK_CYCLES = restart_pkg::TENTH_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Settings
  input  wire logic                        settings_load,
  input  wire logic [3:0]                  retry_budget_setting,
  input  wire logic [9:0]                  restart_delay_setting,
  input  wire logic [restart_pkg::FLY_W-1:0] flying_start_settings,
  // Drive events
  input  wire logic                        trip,
  input  wire logic [restart_pkg::CAUSE_W-1:0] trip_cause,
  input  wire logic                        run_cmd,
  // Manual reset sources
  input  wire logic                        terminal_reset,
  input  wire logic                        keypad_stop_reset,
  // Outputs to the drive
  output logic                             output_enable,
  output logic                             restart_pulse,
  output logic [restart_pkg::FLY_W-1:0]    restart_accel_mode,
  output logic                             trip_latched,
  output logic [3:0]                       retries_left
);
  import restart_pkg::*;

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  logic [3:0] budget;
  logic [9:0] delay_set;
  wire        budget_ok = (retry_budget_setting <= BUDGET_MAX);
  wire        delay_ok  = (restart_delay_setting <= DELAY_MAX);

  // Out-of-range writes are ignored so a bad value never runs the motor
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      budget    <= BUDGET_RESET;
      delay_set <= DELAY_RESET;
    end else if (settings_load) begin
      if (budget_ok) budget <= retry_budget_setting;
      if (delay_ok) delay_set <= restart_delay_setting;
    end
  end

  // ----------------------------------------------------------------
  // Tenth-second timebase
  // ----------------------------------------------------------------
  logic tick;
  tick_divider #(.PERIOD(TICK_CYCLES)) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  seq_state_type state;
  seq_state_type next_state;
  logic [9:0]    timer;
  logic [9:0]    quiet;
  logic          quiet_run;
  logic          run_seen;

  wire manual_reset = terminal_reset | keypad_stop_reset;
  wire excluded     = trip_cause[CAUSE_UNDERVOLT] |
                      trip_cause[CAUSE_ESTOP]     |
                      trip_cause[CAUSE_OVERHEAT]  |
                      trip_cause[CAUSE_SELFDIAG];
  wire exhausted    = (retries_left == 4'h0);
  wire delay_done   = (timer >= delay_set);
  // A manual reset in the same cycle wins: no restart pulse or decrement, but the sequencer still goes to run
  wire fire         = (state == ST_WAIT) && delay_done &&
                      !manual_reset;
  wire quiet_done   = quiet_run && tick && (quiet == QUIET_COUNT - 10'h001);
  wire trip_in_run  = (state == ST_RUN) && trip;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A trip while waiting keeps waiting on the same retry decision
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (trip) begin
          if (excluded || exhausted) next_state = ST_LOCKED;
          else next_state = ST_TRIPPED;
        end
      end
      ST_TRIPPED: begin
        if (manual_reset) next_state = ST_RUN;
        else if (run_seen) next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (manual_reset) next_state = ST_RUN;
        else if (delay_done) next_state = ST_RUN;
      end
      ST_LOCKED: begin
        if (manual_reset) next_state = ST_RUN;
      end
      default: next_state = ST_LOCKED;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) state <= ST_RUN;
    else state <= next_state;
  end

  // Run command is taken on any cycle in the tripped state; a level held at trip is taken too
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) run_seen <= 1'b0;
    else if (state != ST_TRIPPED) run_seen <= 1'b0;
    else if (run_cmd) run_seen <= 1'b1;
  end

  // Delay timer counts tenths while waiting
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) timer <= 10'h000;
    else if (state != ST_WAIT) timer <= 10'h000;
    else if (tick && !delay_done) timer <= timer + 10'h001;
  end

  // ----------------------------------------------------------------
  // Retry counter and quiet window
  // ----------------------------------------------------------------
  // Reset and quiet reload beat the decrement; a trip stops the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retries_left <= BUDGET_RESET;
      quiet_run    <= 1'b0;
      quiet        <= 10'h000;
    end else begin
      if (manual_reset) retries_left <= budget;
      else if (quiet_done) retries_left <= budget;
      else if (fire) retries_left <= retries_left - 4'h1;
      if (fire) begin
        quiet_run <= 1'b1;
        quiet     <= 10'h000;
      end else if (trip_in_run || quiet_done || manual_reset) begin
        quiet_run <= 1'b0;
      end else if (quiet_run && tick) begin
        quiet <= quiet + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      output_enable      <= 1'b1;
      restart_pulse      <= 1'b0;
      restart_accel_mode <= '0;
      trip_latched       <= 1'b0;
    end else begin
      output_enable <= (next_state == ST_RUN);
      restart_pulse <= fire;
      if (fire) restart_accel_mode <= flying_start_settings;
      trip_latched  <= (next_state == ST_LOCKED);
    end
  end
endmodule // fault_auto_restart_sequencer

// ### test/restart_partner.sv
// Keypad and terminal block model driving run and reset inputs
`timescale 1ns/1ps
module restart_partner (
  // Clock and requests from the bench
  input  wire logic clk,
  input  wire logic run_req,
  input  wire logic term_req,
  input  wire logic key_req,
  // Lines into the block
  output logic      run_cmd,
  output logic      terminal_reset,
  output logic      keypad_stop_reset
);
  initial {run_cmd, terminal_reset, keypad_stop_reset} = 3'h0;
  // Lines move 1 ns after the edge, like a real operator input
  always @(posedge clk) begin
    run_cmd <= #1 run_req;
    terminal_reset <= #1 term_req;
    keypad_stop_reset <= #1 key_req;
  end
endmodule // restart_partner

// ### test/restart_chk.sv
// Checker of the restart sequencer ports
`timescale 1ns/1ps
module restart_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Inputs of the block
  input wire logic       trip,
  input wire logic [3:0] trip_cause,
  input wire logic [3:0] flying_start_settings,
  input wire logic       terminal_reset,
  input wire logic       keypad_stop_reset,
  // Outputs of the block
  input wire logic       output_enable,
  input wire logic       restart_pulse,
  input wire logic [3:0] restart_accel_mode,
  input wire logic       trip_latched,
  input wire logic [3:0] retries_left
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Manual reset sources combined
  wire man = terminal_reset | keypad_stop_reset;
  pulse_one_a: assert property (restart_pulse |=> !restart_pulse)
    else $error("restart pulse longer than one cycle");
  pulse_dec_a: assert property (restart_pulse |->
    retries_left == $past(retries_left) - 4'h1)
    else $error("retries not decremented");
  zero_stop_a: assert property (restart_pulse |->
    $past(retries_left) != 4'h0)
    else $error("restart with no retries");
  pulse_on_a: assert property (restart_pulse |-> output_enable)
    else $error("output off at restart");
  accel_cap_a: assert property (restart_pulse |->
    restart_accel_mode == $past(flying_start_settings))
    else $error("accel mode not captured");
  lock_off_a: assert property (trip_latched |-> !output_enable)
    else $error("output on while latched");
  man_clear_a: assert property (man |=> !trip_latched)
    else $error("manual reset left trip latched");
  excl_lock_a: assert property (trip && |trip_cause &&
    output_enable && !man |=> !output_enable ##[0:2] trip_latched)
    else $error("excluded trip not latched");
  cover property (restart_pulse);
  cover property ($rose(trip_latched));
  cover property ($rose(output_enable));
endmodule // restart_chk
bind fault_auto_restart_sequencer restart_chk chk (.clk(clk), .nrst(nrst),
  .trip(trip), .trip_cause(trip_cause),
  .flying_start_settings(flying_start_settings),
  .terminal_reset(terminal_reset), .keypad_stop_reset(keypad_stop_reset),
  .output_enable(output_enable), .restart_pulse(restart_pulse),
  .restart_accel_mode(restart_accel_mode), .trip_latched(trip_latched),
  .retries_left(retries_left));

// ### test/tb_fault_auto_restart_sequencer.sv
// Self-checking bench of the fault auto-restart sequencer
`timescale 1ns/1ps
module tb_fault_auto_restart_sequencer;
  import restart_pkg::*;
  logic clk = 0, nrst = 0, ld = 0, trip = 0, rq = 0, tq = 0, kq = 0;
  logic [3:0] bud = 4'h2, cause = 4'h0, fly = 4'h5, left;
  logic run, trm, key, oe, pls, lat;
  logic [3:0] mode;
  logic [9:0] dly = 10'h002;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  restart_partner P (.clk(clk), .run_req(rq), .term_req(tq), .key_req(kq),
    .run_cmd(run), .terminal_reset(trm), .keypad_stop_reset(key));
  fault_auto_restart_sequencer #(.TICK_CYCLES(4)) DUT (.clk(clk),
    .nrst(nrst), .settings_load(ld), .retry_budget_setting(bud),
    .restart_delay_setting(dly), .flying_start_settings(fly),
    .trip(trip), .trip_cause(cause), .run_cmd(run), .terminal_reset(trm),
    .keypad_stop_reset(key), .output_enable(oe), .restart_pulse(pls),
    .restart_accel_mode(mode), .trip_latched(lat), .retries_left(left));
  initial forever #4 clk = ~clk;
  // Hang guard: the tests need well under this many cycles
  always @(posedge clk) if (++cyc > 20000) begin
    n_mismatch++;
    results;
  end
  task step(int n = 1);
    repeat (n) @(posedge clk) #1;
  endtask
  task check(logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Trip with a cause, then run command raised after it
  task trip_run(logic [3:0] c);
    rq = 0;
    cause = c;
    trip = 1;
    step;
    trip = 0;
    step;
    check(oe, 1'b0);
    rq = 1;
  endtask
  task man_reset(logic k);
    {kq, tq} = {k, !k};
    step;
    {kq, tq} = 2'h0;
    step(3);
  endtask
  task restart_once(logic [3:0] exp);
    int i;
    trip_run(4'h0);
    for (i = 0; i < 200 && pls !== 1'b1; i++) step;
    // Two tenths of four cycles each, plus run pickup and tick phase
    check((i >= 9 && i <= 12), 1'b1);
    check(pls, 1'b1);
    check(left, exp);
    check(mode, fly);
    step;
  endtask
  task t_defaults;
    check(left, 4'h0);
    check(oe, 1'b1);
    trip_run(4'h0);
    step(30);
    check(lat, 1'b1);
    man_reset(0);
    $display("test defaults done");
  endtask
  task t_retries;
    ld = 1;
    step;
    ld = 0;
    man_reset(0);
    check(left, 4'h2);
    restart_once(4'h1);
    step(1300);
    check(left, 4'h2);
    restart_once(4'h1);
    restart_once(4'h0);
    trip_run(4'h0);
    step(30);
    check(lat, 1'b1);
    man_reset(1);
    check({lat, left}, 8'h02);
    $display("test retries done");
  endtask
  task t_excluded;
    int i;
    for (i = 0; i < 4; i++) begin
      trip_run(4'h1 << i);
      step(30);
      check({lat, left}, 8'h12);
      man_reset(i[0]);
    end
    $display("test excluded done");
  endtask
  // Out-of-range settings are ignored: budget and delay stay as loaded
  task t_range;
    bud = 4'hb;
    dly = 10'h259;
    ld = 1;
    step;
    ld = 0;
    man_reset(0);
    check(left, 4'h2);
    restart_once(4'h1);
    $display("test range done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    step(4);
    nrst = 1;
    step;
    t_defaults;
    t_retries;
    t_excluded;
    t_range;
    results;
  end
endmodule // tb_fault_auto_restart_sequencer
